// file: core/izl_regs.svh
// Constants of the id-read, zone-lock and freeze command block.
// Assumes izl_pkg holds the types and mclk runs at 10 MHz.
`ifndef IZL_REGS_SVH
`define IZL_REGS_SVH

// Opcodes in the upper nibble of the device address byte
`define IZL_OP_ID     4'hC
`define IZL_OP_ZONE   4'h7
`define IZL_OP_FRZ    4'h1
`define IZL_OP_ARR    4'hA
// Client address bits of the device address byte
`define IZL_CLIENT    3'h0
// Lock flag addresses, one hot
`define IZL_ZONE0     4'h1
`define IZL_ZONE1     4'h2
`define IZL_ZONE2     4'h4
`define IZL_ZONE3     4'h8
// Fixed data values
`define IZL_ONES      8'hFF
`define IZL_ZERO      8'h00
`define IZL_FRZ_ADDR  8'h55
`define IZL_FRZ_DATA  8'hAA
// Last identification byte index
`define IZL_ID_LAST   2'h2
// Timing: self_timed_write_duration and line_discharge_abort_time
`define IZL_CLK_KHZ   10000
`define IZL_WR_MS     5
`define IZL_WR_CYC    (`IZL_WR_MS * `IZL_CLK_KHZ)
`define IZL_DSCHG_US  150
`define IZL_DSCHG_CYC (`IZL_DSCHG_US * `IZL_CLK_KHZ / 1000)
// Host controller register offsets
`define IZL_CMD_OFS   4'h0
`define IZL_STAT_OFS  4'h4
`define IZL_RES_OFS   4'h8

`endif

// file: core/izl_pkg.sv
// Types shared by both ends of the zone-lock link.
// Assumes nothing beyond a SystemVerilog compiler.
package izl_pkg;
	// Link event kinds sent by the host
	typedef enum logic [2:0] {
		LK_START, LK_BYTE, LK_STOP, LK_READ, LK_MACK
	} izl_kind_t;
	// Host commands
	typedef enum logic [2:0] {
		OP_ID, OP_ZREAD, OP_ZSET, OP_FREEZE, OP_AWRITE, OP_ABORT
	} izl_op_t;
	// One host step on the link
	typedef struct packed {
		izl_kind_t  kind;
		logic [7:0] data;
	} izl_step_t;
endpackage

// file: core/izl_link_if.sv
// Byte-level link between host controller and device end.
// Assumes both ends share mclk; bit framing is outside.
`timescale 1ns/1ps
interface izl_link_if import izl_pkg::*; ();
	// Host to device
	logic       reqValid;
	izl_kind_t  reqKind;
	logic [7:0] reqByte;
	logic       lineLow;
	// Device to host
	logic       rspValid;
	logic       rspAck;
	logic [7:0] rspByte;
	// Device end
	modport dev (input reqValid, reqKind, reqByte, lineLow,
		output rspValid, rspAck, rspByte);
	// Host end
	modport host (output reqValid, reqKind, reqByte, lineLow,
		input rspValid, rspAck, rspByte);
endinterface

// file: core/izl_device.sv
// Device end: id query, zone lock flags and freeze commands.
// Assumes the host issues one link event at a time on mclk.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "izl_regs.svh"
module izl_device import izl_pkg::*; #(
	// Write cycle length in clocks; shorten in simulation
	parameter int          WR_CYC  = `IZL_WR_CYC,
	// Identity fields; values are arbitrary
	parameter logic [11:0] MAKER   = 12'h05A3,
	parameter logic [8:0]  DEVCODE = 9'h00A6,
	parameter logic [2:0]  REV     = 3'h1
) (
	// Clock and resets
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       nvClear,
	// Link to the host
	izl_link_if.dev         lnk,
	// Lock state
	output logic [3:0]      zoneLock,
	output logic            frozen,
	output logic            busy,
	// Array writes that passed the lock check
	output logic            arrWrStb,
	output logic [6:0]      arrWrAddr,
	output logic [7:0]      arrWrData
);
	// Command states
	typedef enum {
		S_IDLE, S_IDRD, S_ZADR, S_ZDAT, S_ZRD, S_STOPW,
		S_FADR, S_FDAT, S_AADR, S_ADAT, S_SKIP, S_BUSY
	} izl_dstate_t;

	localparam logic [23:0] ID_CODE = {MAKER, DEVCODE, REV};
	localparam int          DS_CYC  = `IZL_DSCHG_CYC;

	// Valid one-hot flag address, else zero
	function automatic logic [3:0] zone_decode(input logic [3:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (a == `IZL_ZONE0 || a == `IZL_ZONE1 ||
			a == `IZL_ZONE2 || a == `IZL_ZONE3) begin
			r = a;
		end
		return r;
	endfunction

	// zone of an array byte address
	function automatic logic [3:0] zone_of(input logic [6:0] a);
		return 4'h1 << a[6:5];
	endfunction

	izl_dstate_t state_reg, state_next;   // Command state
	logic [3:0]  zoneLock_reg;            // Nonvolatile lock flags
	logic        frozen_reg;              // Nonvolatile freeze flag
	logic [3:0]  zoneSel_reg, zoneSel_next;   // Addressed flag
	logic [3:0]  pendZone_reg, pendZone_next; // Flag to program
	logic        pendFrz_reg, pendFrz_next;   // Freeze to program
	logic [1:0]  idPtr_reg, idPtr_next;   // Id byte pointer
	logic [6:0]  arrAddr_reg, arrAddr_next;   // Array address
	logic        arrWr_reg, arrWr_next;   // Array write pulse
	logic [7:0]  arrDat_reg;              // Array write data
	logic        rspV_reg, rspV_next;     // Answer strobe
	logic        rspA_reg, rspA_next;     // Answer ACK
	logic [7:0]  rspB_reg, rspB_next;     // Answer byte
	logic [31:0] wrCnt_reg;               // Write cycle timer
	logic [31:0] dsCnt_reg;               // Line-low timer
	logic        busy_reg;                // Write cycle running

	// Link event decode
	wire        reqStart = lnk.reqValid && lnk.reqKind == LK_START;
	wire        reqByte  = lnk.reqValid && lnk.reqKind == LK_BYTE;
	// a stop is only an LK_STOP link event
	wire        reqStop  = lnk.reqValid && lnk.reqKind == LK_STOP;
	wire        reqRead  = lnk.reqValid && lnk.reqKind == LK_READ;
	wire        reqMack  = lnk.reqValid && lnk.reqKind == LK_MACK;
	wire [3:0]  opc      = lnk.reqByte[7:4];
	wire        adrOk    = lnk.reqByte[3:1] == `IZL_CLIENT;
	wire        rdDir    = lnk.reqByte[0];
	wire [3:0]  zoneHot  = zone_decode(lnk.reqByte[3:0]);
	wire        selLocked = |(zoneSel_reg & zoneLock_reg);
	// lock check of the latched array address
	wire        arrLocked = |(zone_of(arrAddr_reg) & zoneLock_reg);
	wire        inBusy   = state_reg == S_BUSY;
	wire        wrDone   = inBusy && wrCnt_reg == 32'(WR_CYC - 1);
	wire        wrAbort  = inBusy && lnk.lineLow &&
		dsCnt_reg == 32'(DS_CYC - 1);
	wire [7:0]  idByte   = idPtr_reg == 2'h0 ? ID_CODE[23:16] :
		idPtr_reg == 2'h1 ? ID_CODE[15:8] : ID_CODE[7:0];

	// Next-state and answer logic
	always_comb begin
		state_next    = state_reg;
		zoneSel_next  = zoneSel_reg;
		pendZone_next = pendZone_reg;
		pendFrz_next  = pendFrz_reg;
		idPtr_next    = idPtr_reg;
		arrAddr_next  = arrAddr_reg;
		arrWr_next    = 1'b0;
		rspV_next     = 1'b0;
		rspA_next     = 1'b0;
		rspB_next     = `IZL_ONES;
		if (inBusy) begin
			// busy: line stays released, all ignored
			rspV_next = reqStart | reqByte | reqRead;
			if (wrAbort || wrDone) begin
				state_next = S_IDLE;
			end
		end else if (reqStop) begin
			// commit only after the acknowledged data byte
			state_next = state_reg == S_STOPW ? S_BUSY : S_IDLE;
		end else if (reqStart) begin
			// Device address byte, also on repeated start
			rspV_next     = 1'b1;
			state_next    = S_SKIP;
			pendZone_next = 4'h0;
			pendFrz_next  = 1'b0;
			if (adrOk) begin
				case (opc)
					`IZL_OP_ID: begin
						if (rdDir) begin
							rspA_next  = 1'b1;
							idPtr_next = 2'h0;
							state_next = S_IDRD;
						end
					end
					`IZL_OP_ZONE: begin
						if (!rdDir) begin
							rspA_next  = 1'b1;
							state_next = S_ZADR;
						end else if (state_reg == S_ZDAT &&
							zoneSel_reg != 4'h0) begin
							rspA_next  = 1'b1;
							state_next = S_ZRD;
						end
					end
					`IZL_OP_FRZ: begin
						if (!rdDir && !frozen_reg) begin
							rspA_next  = 1'b1;
							state_next = S_FADR;
						end
					end
					`IZL_OP_ARR: begin
						if (!rdDir) begin
							rspA_next  = 1'b1;
							state_next = S_AADR;
						end
					end
					default: begin
						rspA_next = 1'b0;
					end
				endcase
			end
		end else if (reqByte) begin
			// Bytes written by the host
			rspV_next  = 1'b1;
			state_next = S_SKIP;
			case (state_reg)
				S_ZADR: begin
					rspA_next    = 1'b1;
					zoneSel_next = zoneHot;
					state_next   = S_ZDAT;
				end
				S_ZDAT: begin
					if (lnk.reqByte == `IZL_ONES && !frozen_reg &&
						zoneSel_reg != 4'h0) begin
						rspA_next     = 1'b1;
						pendZone_next = zoneSel_reg;
						state_next    = S_STOPW;
					end
				end
				S_FADR: begin
					if (lnk.reqByte == `IZL_FRZ_ADDR) begin
						rspA_next  = 1'b1;
						state_next = S_FDAT;
					end
				end
				S_FDAT: begin
					if (lnk.reqByte == `IZL_FRZ_DATA) begin
						rspA_next    = 1'b1;
						pendFrz_next = 1'b1;
						state_next   = S_STOPW;
					end
				end
				S_AADR: begin
					rspA_next    = 1'b1;
					arrAddr_next = lnk.reqByte[6:0];
					state_next   = S_ADAT;
				end
				S_ADAT: begin
					// locked zone: NACK and ready at once
					if (arrLocked) begin
						state_next = S_IDLE;
					end else begin
						rspA_next  = 1'b1;
						arrWr_next = 1'b1;
					end
				end
				default: begin
					rspA_next = 1'b0;
				end
			endcase
		end else if (reqRead) begin
			// Bytes read by the host
			rspV_next = 1'b1;
			if (state_reg == S_IDRD) begin
				rspB_next = idByte;
			end else if (state_reg == S_ZRD) begin
				// flag reads as 00h or FFh
				rspB_next = selLocked ? `IZL_ONES : `IZL_ZERO;
			end
		end else if (reqMack) begin
			// Host answer after a read byte
			if (state_reg == S_IDRD && !lnk.reqByte[0]) begin
				// ACK continues, wrapping after the third
				idPtr_next = idPtr_reg == `IZL_ID_LAST ? 2'h0 :
					idPtr_reg + 2'h1;
			end else begin
				state_next = S_SKIP;
			end
		end
	end

	// Lock flags survive srst; only nvClear blanks them
	always_ff @(posedge mclk) begin
		if (nvClear) begin
			zoneLock_reg <= 4'h0;
			frozen_reg   <= 1'b0;
		end else if (wrDone && !wrAbort) begin
			zoneLock_reg <= zoneLock_reg | pendZone_reg;
			frozen_reg   <= frozen_reg | pendFrz_reg;
		end
	end

	// Write cycle and discharge timers
	always_ff @(posedge mclk) begin
		if (srst || !inBusy) begin
			wrCnt_reg <= 32'h0000_0000;
			dsCnt_reg <= 32'h0000_0000;
		end else begin
			wrCnt_reg <= wrCnt_reg + 32'h0000_0001;
			dsCnt_reg <= lnk.lineLow ? dsCnt_reg + 32'h0000_0001 :
				32'h0000_0000;
		end
	end

	// Command state registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg    <= S_IDLE;
			zoneSel_reg  <= 4'h0;
			pendZone_reg <= 4'h0;
			pendFrz_reg  <= 1'b0;
			idPtr_reg    <= 2'h0;
			arrAddr_reg  <= 7'h00;
			arrWr_reg    <= 1'b0;
			arrDat_reg   <= 8'h00;
			rspV_reg     <= 1'b0;
			rspA_reg     <= 1'b0;
			rspB_reg     <= 8'h00;
			busy_reg     <= 1'b0;
		end else begin
			state_reg    <= state_next;
			zoneSel_reg  <= zoneSel_next;
			pendZone_reg <= pendZone_next;
			pendFrz_reg  <= pendFrz_next;
			idPtr_reg    <= idPtr_next;
			arrAddr_reg  <= arrAddr_next;
			arrWr_reg    <= arrWr_next;
			arrDat_reg   <= arrWr_next ? lnk.reqByte : arrDat_reg;
			rspV_reg     <= rspV_next;
			rspA_reg     <= rspA_next;
			rspB_reg     <= rspB_next;
			busy_reg     <= state_next == S_BUSY;
		end
	end

	// Outputs straight from registers
	assign lnk.rspValid = rspV_reg;
	assign lnk.rspAck   = rspA_reg;
	assign lnk.rspByte  = rspB_reg;
	assign zoneLock     = zoneLock_reg;
	assign frozen       = frozen_reg;
	assign busy         = busy_reg;
	assign arrWrStb     = arrWr_reg;
	assign arrWrAddr    = arrAddr_reg;
	assign arrWrData    = arrDat_reg;
endmodule

// file: core/izl_host.sv
// Host end: runs zone-lock link sequences on software command.
// Assumes an AXI4-Lite master with 32-bit data on mclk.
`timescale 1ns/1ps
`include "izl_regs.svh"
module izl_host import izl_pkg::*; (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Link to the device
	izl_link_if.host         lnk
);
	typedef enum {H_IDLE, H_SEND, H_WAIT, H_ABORT} izl_hstate_t;
	localparam int DS_CYC = `IZL_DSCHG_CYC;

	// Step idx of command op; a STOP ends every sequence
	function automatic izl_step_t step(input izl_op_t op,
		input logic [2:0] idx, input logic [7:0] a0,
		input logic [7:0] a1);
		izl_step_t s;
		s = '{LK_STOP, `IZL_ONES};
		case (op)
			OP_ID: begin
				// three reads, NACK after the last
				if (idx == 3'h0) s = '{LK_START, {`IZL_OP_ID, `IZL_CLIENT, 1'b1}};
				else if (idx < 3'h7) s = idx[0] ? '{LK_READ, `IZL_ONES} :
					'{LK_MACK, {7'h00, idx == 3'h6}};
			end
			OP_ZREAD: begin
				case (idx)
					3'h0: s = '{LK_START, {`IZL_OP_ZONE, `IZL_CLIENT, 1'b0}};
					3'h1: s = '{LK_BYTE, a0};
					3'h2: s = '{LK_START, {`IZL_OP_ZONE, `IZL_CLIENT, 1'b1}};
					3'h3: s = '{LK_READ, `IZL_ONES};
					3'h4: s = '{LK_MACK, 8'h01};
					default: s = '{LK_STOP, `IZL_ONES};
				endcase
			end
			default: begin
				case (idx)
					3'h0: s = '{LK_START, {op == OP_FREEZE ? `IZL_OP_FRZ :
						op == OP_ZSET ? `IZL_OP_ZONE : `IZL_OP_ARR,
						`IZL_CLIENT, 1'b0}};
					3'h1: s = '{LK_BYTE, op == OP_FREEZE ? `IZL_FRZ_ADDR : a0};
					3'h2: s = '{LK_BYTE, op == OP_FREEZE ? `IZL_FRZ_DATA :
						op == OP_ZSET ? `IZL_ONES : a1};
					default: s = '{LK_STOP, `IZL_ONES};
				endcase
			end
		endcase
		return s;
	endfunction

	izl_hstate_t st_reg;              // Sequencer state
	izl_op_t     op_reg;              // Current command
	logic [2:0]  idx_reg;             // Step index
	logic [7:0]  arg0_reg, arg1_reg;  // Command arguments
	logic        fail_reg;            // A NACK was seen
	logic        done_reg;            // Command finished
	logic [23:0] res_reg;             // Bytes read
	logic [31:0] dsCnt_reg;           // Abort hold counter
	logic        reqV_reg, low_reg;   // Link drive
	izl_step_t   cur_reg;             // Step on the link
	logic        awHeld_reg, wHeld_reg;
	logic [3:0]  awAddr_reg;
	logic [31:0] wData_reg;
	logic        bV_reg, rV_reg;
	logic [31:0] rData_reg;

	// After a NACK only the closing stop is sent
	wire izl_step_t nxt = fail_reg ? '{LK_STOP, `IZL_ONES} :
		step(op_reg, idx_reg, arg0_reg, arg1_reg);
	wire wrGo  = awHeld_reg && wHeld_reg && !bV_reg;
	wire cmdGo = wrGo && awAddr_reg == `IZL_CMD_OFS &&
		wData_reg[0] == 1'b1 && st_reg == H_IDLE;
	wire [31:0] rdMux = s_axi_araddr == `IZL_STAT_OFS ?
		{29'h0, !fail_reg, done_reg, st_reg != H_IDLE} :
		s_axi_araddr == `IZL_RES_OFS ? {8'h00, res_reg} : 32'h0000_0000;

	// Sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg <= H_IDLE; op_reg <= OP_ID; idx_reg <= 3'h0;
			arg0_reg <= 8'h00; arg1_reg <= 8'h00; fail_reg <= 1'b0;
			done_reg <= 1'b0; res_reg <= 24'h00_0000;
			dsCnt_reg <= 32'h0000_0000; reqV_reg <= 1'b0;
			low_reg <= 1'b0; cur_reg <= '{LK_STOP, `IZL_ONES};
		end else begin
			reqV_reg <= 1'b0;
			case (st_reg)
				H_IDLE: if (cmdGo) begin
					op_reg   <= izl_op_t'(wData_reg[3:1]);
					arg0_reg <= wData_reg[15:8];
					arg1_reg <= wData_reg[23:16];
					idx_reg  <= 3'h0;
					fail_reg <= 1'b0;
					done_reg <= 1'b0;
					dsCnt_reg <= 32'h0000_0000;
					st_reg   <= izl_op_t'(wData_reg[3:1]) == OP_ABORT ?
						H_ABORT : H_SEND;
				end
				H_SEND: begin
					reqV_reg <= 1'b1;
					cur_reg  <= nxt;
					idx_reg  <= idx_reg + 3'h1;
					if (nxt.kind == LK_STOP) begin
						st_reg <= H_IDLE; done_reg <= 1'b1;
					end else if (nxt.kind != LK_MACK) st_reg <= H_WAIT;
				end
				H_WAIT: if (lnk.rspValid) begin
					st_reg <= H_SEND;
					if (cur_reg.kind == LK_READ)
						res_reg <= {res_reg[15:0], lnk.rspByte};
					else if (!lnk.rspAck) fail_reg <= 1'b1;
				end
				H_ABORT: begin
					// hold line low for the discharge time
					low_reg   <= dsCnt_reg != 32'(DS_CYC);
					dsCnt_reg <= dsCnt_reg + 32'h0000_0001;
					if (dsCnt_reg == 32'(DS_CYC)) begin
						st_reg <= H_IDLE; done_reg <= 1'b1;
					end
				end
				default: st_reg <= H_IDLE;
			endcase
		end
	end

	// AXI4-Lite write channel holding and response
	always_ff @(posedge mclk) begin
		if (srst) begin
			awHeld_reg <= 1'b0; wHeld_reg <= 1'b0; bV_reg <= 1'b0;
			awAddr_reg <= 4'h0; wData_reg <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1; awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1; wData_reg <= s_axi_wdata;
			end
			if (wrGo) begin
				awHeld_reg <= 1'b0; wHeld_reg <= 1'b0; bV_reg <= 1'b1;
			end
			if (bV_reg && s_axi_bready) bV_reg <= 1'b0;
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge mclk) begin
		if (srst) begin
			rV_reg <= 1'b0; rData_reg <= 32'h0000_0000;
		end else if (s_axi_arvalid && !rV_reg) begin
			rV_reg <= 1'b1; rData_reg <= rdMux;
		end else if (rV_reg && s_axi_rready) rV_reg <= 1'b0;
	end

	// Ports; the line is driven only by an abort command
	assign s_axi_awready = !awHeld_reg && !bV_reg;
	assign s_axi_wready  = !wHeld_reg && !bV_reg;
	assign s_axi_bvalid  = bV_reg;
	assign s_axi_bresp   = 2'h0;
	assign s_axi_arready = !rV_reg;
	assign s_axi_rvalid  = rV_reg;
	assign s_axi_rdata   = rData_reg;
	assign s_axi_rresp   = 2'h0;
	assign lnk.reqValid  = reqV_reg;
	assign lnk.reqKind   = cur_reg.kind;
	assign lnk.reqByte   = cur_reg.data;
	assign lnk.lineLow   = low_reg;
endmodule

// file: verification/izl_link_chk.sv
// Assertion checker for the byte link between host and device.
// Assumes one mclk domain and the link signals as plain inputs.
`timescale 1ns/1ps
module izl_link_chk import izl_pkg::*; #(
	// Identity value the device reports
	parameter logic [23:0] ID = 24'h00_0000
) (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       srst,
	// Link signals
	input wire logic       reqValid,
	input wire izl_kind_t  reqKind,
	input wire logic [7:0] reqByte,
	input wire logic       rspValid,
	input wire logic       rspAck,
	input wire logic [7:0] rspByte
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// Last start byte, first byte after it, byte and read counts
	logic [7:0] stReg;
	logic [7:0] adReg;
	logic [1:0] nbReg;
	logic [1:0] rdReg;
	// Request kinds of this cycle
	wire logic isStart = reqValid && reqKind == LK_START;
	wire logic isByte  = reqValid && reqKind == LK_BYTE;
	wire logic isRead  = reqValid && reqKind == LK_READ;
	// Identity byte due at this read, top byte first
	wire logic [7:0] idByte = rdReg == 2'h0 ? ID[23:16] :
		rdReg == 2'h1 ? ID[15:8] : ID[7:0];
	// Track where the current sequence stands
	always_ff @(posedge mclk) begin
		if (srst || isStart) begin
			stReg <= srst ? 8'h00 : reqByte;
			adReg <= 8'h00;
			nbReg <= 2'h0;
			rdReg <= 2'h0;
		end else if (isByte) begin
			nbReg <= nbReg == 2'h3 ? nbReg : nbReg + 2'h1;
			adReg <= nbReg == 2'h0 ? reqByte : adReg;
		end else if (isRead) begin
			rdReg <= rdReg == 2'h2 ? 2'h0 : rdReg + 2'h1;
		end
	end
	id_rd_ack_a:
		assert property (isStart && reqByte == 8'hC1 |=> rspValid && rspAck)
		else $error("id read start not acknowledged");
	id_byte_a:
		assert property (isRead && stReg == 8'hC1 |=> rspByte == $past(idByte))
		else $error("id byte out of order");
	rsp_due_a:
		assert property (isStart || isByte || isRead |=> rspValid)
		else $error("answer missing one cycle after request");
	rsp_pulse_a:
		assert property (rspValid |=> !rspValid)
		else $error("answer longer than one cycle");
	zone_rd_a:
		assert property (isRead && stReg == 8'h71 |=>
			rspByte == 8'h00 || rspByte == 8'hFF)
		else $error("flag read value not 00 or FF");
	frz_good_a:
		assert property (isByte && stReg == 8'h10 && nbReg == 2'h0 &&
			reqByte == 8'h55 |=> rspValid && rspAck)
		else $error("freeze address byte not acknowledged");
	zone_bad_a:
		assert property (isByte && stReg == 8'h70 && nbReg == 2'h1 &&
			!(adReg[3:0] inside {4'h1, 4'h2, 4'h4, 4'h8}) |=> !rspAck)
		else $error("byte after unknown flag address acknowledged");
	stop_quiet_a:
		assert property (reqValid && reqKind == LK_STOP |=> !rspValid)
		else $error("answer after stop");
	// Main scenarios reached
	cover property (isRead && stReg == 8'hC1);
	cover property (isRead && stReg == 8'h71);
	cover property (isByte && stReg == 8'h10 && nbReg == 2'h1);
endmodule

// file: verification/izl_tb.sv
// Testbench: host and device ends joined over one link.
// Assumes software reaches the host over AXI4-Lite only.
`timescale 1ns/1ps
`include "izl_regs.svh"
module tb import izl_pkg::*; ;
	// Identity fields; values are arbitrary
	localparam logic [11:0] MK = 12'h3C7;
	localparam logic [8:0]  DV = 9'h0B2;
	localparam logic [2:0]  RV = 3'h5;
	localparam logic [23:0] ID = {MK, DV, RV};
	// Clock, resets and counters
	logic mclk, srst, nvClear;
	int   mismatches = 0, comparisons = 0, cyc = 0, wrCnt = 0;
	// AXI4-Lite master side
	logic [3:0]       awaddr, araddr;
	logic [31:0]      wdata;
	logic             awvalid, wvalid, bready, arvalid, rready;
	wire logic        awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	// Device outputs
	wire logic [3:0]  zoneLock;
	wire logic        frozen, busy, arrWrStb;
	wire logic [6:0]  arrWrAddr;
	wire logic [7:0]  arrWrData;
	// Model flags and last array commit seen
	logic [3:0]       lkm;
	logic [14:0]      wrSeen;
	izl_link_if link ();
	izl_host u_izl_host (.mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .lnk(link.host));
	izl_device #(.WR_CYC(2000), .MAKER(MK), .DEVCODE(DV), .REV(RV))
		u_izl_device (.mclk(mclk), .srst(srst), .nvClear(nvClear),
		.lnk(link.dev), .zoneLock(zoneLock), .frozen(frozen), .busy(busy),
		.arrWrStb(arrWrStb), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData));
	izl_link_chk #(.ID(ID)) u_izl_link_chk (.mclk(mclk), .srst(srst),
		.reqValid(link.reqValid), .reqKind(link.reqKind),
		.reqByte(link.reqByte), .rspValid(link.rspValid),
		.rspAck(link.rspAck), .rspByte(link.rspByte));
	// Free running clock
	always #50 mclk = ~mclk;
	// Count array commits and cut a hang short
	always @(posedge mclk) begin
		cyc++;
		if (arrWrStb === 1'b1) begin
			wrCnt++;
			wrSeen <= {arrWrAddr, arrWrData};
		end
		if (cyc == 30000) begin
			mismatches++;
			stop_test();
		end
	end
	// Verdict and end of run
	task stop_test;
		if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Compare one result
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Bus write; each channel released when taken
	task axw(input logic [3:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(posedge mclk);
		while (awvalid || wvalid || bready) begin
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) chk("write response", 32'h0, {30'h0, bresp});
			if (bvalid) bready <= 1'b0;
			@(posedge mclk);
		end
	endtask
	// Bus read; data taken at the edge rvalid is seen
	task axr(input logic [3:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge mclk);
		while (rready) begin
			if (arready) arvalid <= 1'b0;
			if (rvalid) d = rdata;
			if (rvalid) chk("read response", 32'h0, {30'h0, rresp});
			if (rvalid) rready <= 1'b0;
			@(posedge mclk);
		end
	endtask
	// Issue one command and wait for done with busy low
	task run(input izl_op_t op, input logic [7:0] a0, input logic [7:0] a1,
		output logic [31:0] res, output logic ok);
		logic [31:0] st;
		axw(`IZL_CMD_OFS, {8'h00, a1, a0, 4'h0, op, 1'b1});
		st = 32'h0;
		while (st[1:0] !== 2'b10) axr(`IZL_STAT_OFS, st);
		ok = st[2];
		axr(`IZL_RES_OFS, res);
	endtask
	// Wait out a self-timed write
	task idle;
		while (busy !== 1'b0) @(posedge mclk);
	endtask
	// Read every flag; upper address nibble is random
	task zscan;
		logic [31:0] r;
		logic        ok;
		for (int z = 0; z < 4; z++) begin
			run(OP_ZREAD, {4'($urandom), 4'h1 << z}, 8'h00, r, ok);
			chk("flag read ok", 32'h1, {31'h0, ok});
			chk("flag read", lkm[z] ? 32'hFF : 32'h0, {24'h0, r[7:0]});
		end
	endtask
	// Main sequence
	initial begin
		logic [31:0] r;
		logic        ok;
		logic [6:0]  a;
		logic [7:0]  d;
		int          z;
		mclk = 1'b0;
		srst = 1'b1;
		nvClear = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 40'h0;
		lkm = 4'h0;
		void'($urandom(28));
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		nvClear <= 1'b0;
		@(posedge mclk);
		run(OP_ID, 8'h00, 8'h00, r, ok);
		chk("id ok", 32'h1, {31'h0, ok});
		chk("id value", {8'h00, ID}, r);
		zscan();
		// Lock a random zone, then ask while its write runs
		z = $urandom_range(3);
		run(OP_ZSET, 8'h01 << z, 8'hFF, r, ok);
		chk("set ok", 32'h1, {31'h0, ok});
		run(OP_ZREAD, 8'h01, 8'h00, r, ok);
		chk("busy refusal", 32'h0, {31'h0, ok});
		chk("busy", 32'h1, {31'h0, busy});
		idle();
		lkm[z] = 1'b1;
		chk("flags", {28'h0, lkm}, {28'h0, zoneLock});
		// Cut a second flag write short by holding the line low
		run(OP_ZSET, 8'h01 << ((z + 1) % 4), 8'hFF, r, ok);
		run(OP_ABORT, 8'h00, 8'h00, r, ok);
		chk("abort ok", 32'h1, {31'h0, ok});
		chk("abort busy", 32'h0, {31'h0, busy});
		chk("abort flags", {28'h0, lkm}, {28'h0, zoneLock});
		run(OP_ZSET, 8'h03, 8'hFF, r, ok);
		chk("unknown flag", 32'h0, {31'h0, ok});
		idle();
		zscan();
		// Array writes at both ends of every zone
		for (int i = 0; i < 8; i++) begin
			a = {i[2:1], i[0] ? 5'h1F : 5'h00};
			d = 8'($urandom);
			z = wrCnt;
			run(OP_AWRITE, {1'b0, a}, d, r, ok);
			chk("array ack", {31'h0, !lkm[i >> 1]}, {31'h0, ok});
			chk("array commits", z + !lkm[i >> 1], wrCnt);
			if (!lkm[i >> 1]) chk("array target", {17'h0, a, d}, wrSeen);
		end
		// Reset in mid-run keeps the flags
		srst <= 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		chk("flags after reset", {28'h0, lkm}, {28'h0, zoneLock});
		run(OP_FREEZE, 8'h00, 8'h00, r, ok);
		chk("freeze ok", 32'h1, {31'h0, ok});
		chk("freeze line", 32'h0, {31'h0, link.lineLow});
		idle();
		chk("frozen", 32'h1, {31'h0, frozen});
		run(OP_FREEZE, 8'h00, 8'h00, r, ok);
		chk("refreeze", 32'h0, {31'h0, ok});
		z = (z + 1) % 4;
		run(OP_ZSET, 8'h01 << (lkm[0] ? 1 : 0), 8'hFF, r, ok);
		chk("frozen set", 32'h0, {31'h0, ok});
		idle();
		zscan();
		stop_test();
	end
endmodule
